/* core/owd_pkg.sv */
// constants shared by the one-time enabled watchdog
package owd_pkg;
  // ---------------------------------------------------------------
  // register addresses on the special function register bus
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_RESTART    = 8'hA6;
  localparam logic [7:0]  ADDR_AUX        = 8'h8E;
  // ---------------------------------------------------------------
  // service key and auxiliary field layout
  // ---------------------------------------------------------------
  localparam logic [7:0]  KEY_FIRST       = 8'h1E;
  localparam logic [7:0]  KEY_SECOND      = 8'hE1;
  localparam int          AUX_IDLE_BIT    = 4;
  localparam int          AUX_RSTO_BIT    = 3;
  localparam logic        AUX_IDLE_RESET  = 1'h0;
  localparam logic        AUX_RSTO_RESET  = 1'h0;
  // ---------------------------------------------------------------
  // counter and reset-out timing
  // ---------------------------------------------------------------
  localparam int          CNT_W           = 14;
  localparam logic [13:0] CNT_TERMINAL    = 14'h3FFF;
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          RST_PULSE_NS    = 384;
  localparam int          RST_PULSE_CYC   =
    (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          PULSE_W         = 7;
  // ---------------------------------------------------------------
  // watchdog states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OWD_OFF, OWD_RUN, OWD_FIRE} owd_state_t;
endpackage : owd_pkg

/* core/owd_key_seq.sv */
// two-write service key detector for the restart register
`timescale 1ns/1ps
module owd_key_seq (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic       clear_in,
  // restart register write
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // completed key
  output logic            key_done_out
);
  logic armed;
  logic next_armed;

  // first key arms; only the second key straight after it completes
  always_comb begin
    next_armed   = armed;
    key_done_out = 1'b0;
    if (wr_in) begin
      key_done_out = armed && (wdata_in == owd_pkg::KEY_SECOND); // RL12
      next_armed   = (wdata_in == owd_pkg::KEY_FIRST);            // RL12
    end
    if (clear_in) begin
      next_armed = 1'b0;
    end
  end

  // armed flag register
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end
endmodule : owd_key_seq

/* core/owd_top.sv */
// one-time enabled watchdog with reset-out drive
// What this block does
// RL1 - watchdog is a 14-bit up-counter with a write-only restart register
// RL2 - after any reset the watchdog is off and does not count
// RL3 - writing 1E then E1 to address A6 enables it
// RL4 - enabled counter advances once per machine cycle while clocked
// RL5 - no software write turns it off; only resets do
// RL6 - overflow drives a high pulse onto the reset pin
// RL7 - the same key pair while enabled restarts the count from zero
// RL8 - reaching 3FFF overflows and resets the whole device
// RL9 - software must service before 16383 machine cycles pass
// RL10 - auxiliary idle bit set halts counting while the device idles
// RL11 - auxiliary reset-out disable bit set leaves the pin input only
// RL12 - only 1E immediately followed by E1 counts; other writes do nothing
`timescale 1ns/1ps
module owd_top (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // special function register bus
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  output logic      [7:0] sfr_rdata_out,
  // core timing and power state
  input  wire logic       machine_cycle_in,
  input  wire logic       idle_in,
  // reset pin, two-way
  input  wire logic       rst_pin_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe_out,
  // status towards the device
  output logic            device_reset_out,
  output logic            wdt_enabled_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  owd_pkg::owd_state_t              state;
  owd_pkg::owd_state_t              next_state;
  logic [owd_pkg::CNT_W-1:0]        count;
  logic [owd_pkg::CNT_W-1:0]        next_count;
  logic [owd_pkg::PULSE_W-1:0]      pulse_cnt;
  logic [owd_pkg::PULSE_W-1:0]      next_pulse_cnt;
  logic                             idle_halt;
  logic                             next_idle_halt;
  logic                             rsto_disable;
  logic                             next_rsto_disable;
  logic [7:0]                       next_rdata;
  logic                             restart_wr;
  logic                             key_done;
  logic                             tick;
  logic                             overflow;
  logic                             firing;

  localparam logic [owd_pkg::PULSE_W-1:0] PULSE_LAST =
    owd_pkg::PULSE_W'(owd_pkg::RST_PULSE_CYC - 1);

  // ---------------------------------------------------------------
  // key detection
  // ---------------------------------------------------------------
  assign restart_wr = sfr_wr_in && (sfr_addr_in == owd_pkg::ADDR_RESTART);
  assign firing     = (state == owd_pkg::OWD_FIRE);

  owd_key_seq u_key (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .clear_in     (firing),
    .wr_in        (restart_wr),
    .wdata_in     (sfr_wdata_in),
    .key_done_out (key_done)
  );

  // counting permission: machine cycle, not halted by idle
  assign tick     = machine_cycle_in && !(idle_in && idle_halt); // RL4 RL10
  assign overflow = tick && (count == owd_pkg::CNT_TERMINAL);    // RL8

  // ---------------------------------------------------------------
  // watchdog state machine and counter
  // ---------------------------------------------------------------
  // a service on the overflow tick wins, so a just-in-time key is honoured
  always_comb begin
    next_state     = state;
    next_count     = count;
    next_pulse_cnt = pulse_cnt;
    unique case (state)
      owd_pkg::OWD_OFF: begin
        next_count = '0;
        if (key_done) begin
          next_state = owd_pkg::OWD_RUN;              // RL3
        end
      end
      owd_pkg::OWD_RUN: begin
        if (key_done) begin
          next_count = '0;                            // RL7
        end else if (overflow) begin
          next_state     = owd_pkg::OWD_FIRE;         // RL8
          next_count     = '0;
          next_pulse_cnt = '0;
        end else if (tick) begin
          next_count = count + 1'b1;                  // RL1 RL4
        end
      end
      owd_pkg::OWD_FIRE: begin
        next_pulse_cnt = pulse_cnt + 1'b1;
        if (pulse_cnt == PULSE_LAST) begin
          next_state = owd_pkg::OWD_OFF;              // RL5
        end
      end
    endcase
  end

  // watchdog registers; off after hardware reset
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state     <= owd_pkg::OWD_OFF;                  // RL2
      count     <= '0;
      pulse_cnt <= '0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // ---------------------------------------------------------------
  // auxiliary control register and read path
  // ---------------------------------------------------------------
  // the overflow reset returns the auxiliary bits to reset at pulse end
  always_comb begin
    next_idle_halt    = idle_halt;
    next_rsto_disable = rsto_disable;
    next_rdata        = 8'h00;
    if (firing) begin
      // bits hold through the pulse so the pin drive choice stays put
      if (pulse_cnt == PULSE_LAST) begin
        next_idle_halt    = owd_pkg::AUX_IDLE_RESET;
        next_rsto_disable = owd_pkg::AUX_RSTO_RESET;  // RL11
      end
    end else if (sfr_wr_in && sfr_addr_in == owd_pkg::ADDR_AUX) begin
      next_idle_halt    = sfr_wdata_in[owd_pkg::AUX_IDLE_BIT]; // RL10
      next_rsto_disable = sfr_wdata_in[owd_pkg::AUX_RSTO_BIT]; // RL11
    end
    // restart register is write only and reads as zero
    if (sfr_rd_in && sfr_addr_in == owd_pkg::ADDR_AUX) begin
      next_rdata[owd_pkg::AUX_IDLE_BIT] = idle_halt;
      next_rdata[owd_pkg::AUX_RSTO_BIT] = rsto_disable;
    end
  end

  // auxiliary and read data registers
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idle_halt     <= owd_pkg::AUX_IDLE_RESET;
      rsto_disable  <= owd_pkg::AUX_RSTO_RESET;       // RL11
      sfr_rdata_out <= 8'h00;
    end else begin
      idle_halt     <= next_idle_halt;
      rsto_disable  <= next_rsto_disable;
      sfr_rdata_out <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // reset pin and device reset
  // ---------------------------------------------------------------
  // pin level is only a report of the outside; the core reset is internal
  assign device_reset_out = firing;                          // RL8
  assign rst_pin_out      = 1'b1;                            // RL6
  assign rst_pin_oe_out   = firing && !rsto_disable;         // RL6 RL11
  assign wdt_enabled_out  = (state == owd_pkg::OWD_RUN);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // helper: cycles the reset pulse has stood so far
  logic [7:0]            ast_fire_len;
  logic [7:0]            next_ast_fire_len;
  localparam logic [7:0] FIRE_CYC = 8'(owd_pkg::RST_PULSE_CYC);

  // pulse length counter, cleared whenever the pulse is not standing
  always_comb begin
    next_ast_fire_len = 8'h00;
    if (firing) begin
      next_ast_fire_len = ast_fire_len + 8'h01;
    end
  end

  // pulse length register
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ast_fire_len <= 8'h00;
    end else begin
      ast_fire_len <= next_ast_fire_len;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  AST_NO_COUNT_OFF: assert property ( // RL2
    state == owd_pkg::OWD_OFF |-> count == '0)
    else $error("counter moves while watchdog is off");
  AST_ENABLE_KEY: assert property ( // RL3
    state == owd_pkg::OWD_OFF && key_done |=> state == owd_pkg::OWD_RUN)
    else $error("key pair did not enable watchdog");
  AST_ENABLE_CAUSE: assert property ( // RL3
    $rose(wdt_enabled_out) |-> $past(restart_wr) &&
      $past(sfr_wdata_in) == owd_pkg::KEY_SECOND)
    else $error("watchdog enabled without second key");
  AST_TICK_INC: assert property ( // RL4
    state == owd_pkg::OWD_RUN && tick && !key_done && !overflow
      |=> count == $past(count) + 1'b1)
    else $error("counter missed a machine cycle");
  AST_IDLE_HALT: assert property ( // RL10
    state == owd_pkg::OWD_RUN && idle_in && idle_halt && !key_done
      |=> $stable(count))
    else $error("counter moved while halted in idle");
  AST_STAYS_ON: assert property ( // RL5
    state == owd_pkg::OWD_RUN && !overflow |=> state == owd_pkg::OWD_RUN)
    else $error("watchdog left run without overflow");
  AST_SERVICE: assert property ( // RL7
    state == owd_pkg::OWD_RUN && key_done |=> count == '0)
    else $error("service did not clear the count");
  AST_OVERFLOW: assert property ( // RL8
    state == owd_pkg::OWD_RUN && overflow && !key_done
      |=> device_reset_out [*8])
    else $error("overflow did not reset the device");
  AST_PULSE_LEN: assert property ( // RL6
    $fell(firing) |-> ast_fire_len == FIRE_CYC)
    else $error("reset pulse length wrong");
  AST_PULSE_MAX: assert property ( // RL6
    firing |-> ast_fire_len < FIRE_CYC)
    else $error("reset pulse too long");
  AST_RSTO_HOLD: assert property ( // RL11
    firing && $past(firing) |-> $stable(rsto_disable))
    else $error("reset-out choice changed during the pulse");
  AST_PIN_DRIVE: assert property ( // RL11
    firing && rsto_disable |-> !rst_pin_oe_out)
    else $error("pin driven while reset-out disabled");
  AST_BAD_KEY: assert property ( // RL12
    restart_wr && sfr_wdata_in != owd_pkg::KEY_SECOND |-> !key_done)
    else $error("wrong byte completed the key");

  COV_ENABLE:   cover property ($rose(wdt_enabled_out));
  COV_SERVICE:  cover property (wdt_enabled_out && key_done);
  COV_OVERFLOW: cover property ($rose(rst_pin_oe_out));
  COV_IDLE:     cover property (wdt_enabled_out && idle_in && idle_halt);
  COV_PIN_IN:   cover property (firing && !rst_pin_oe_out && !rst_pin_in);
endmodule : owd_top

/* dv/one_time_enabled_watchdog_tb.sv */
// self-checking bench for the one-time enabled watchdog
`timescale 1ns/1ps
module one_time_enabled_watchdog_tb;
  // ---------------------------------------------------------------
  // stimulus and observation signals
  // ---------------------------------------------------------------
  logic       sys_clk_in = 1'b0;
  logic       reset_in   = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
  logic       sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, machine_cycle_in = 1'b0;
  logic       idle_in = 1'b0, rst_pin_in = 1'b0, rst_pin_out;
  logic       rst_pin_oe_out, device_reset_out, wdt_enabled_out, rd_q;
  logic [7:0] exp_q[$];
  integer     seed = 32'h1a610ae1;
  int         fail_count = 0, compares = 0, n;
  owd_top i_owd_top (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out), .machine_cycle_in(machine_cycle_in),
    .idle_in(idle_in), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_out(rst_pin_oe_out), .device_reset_out(device_reset_out),
    .wdt_enabled_out(wdt_enabled_out));
  // ---------------------------------------------------------------
  // clock, read monitor and watchdog
  // ---------------------------------------------------------------
  initial forever #2 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) rd_q <= sfr_rd_in;
  // read data stands one cycle, so it is taken at the next falling edge
  initial forever begin
    @(negedge sys_clk_in);
    if (rd_q === 1'b1 && exp_q.size() > 0) begin
      check(sfr_rdata_out, exp_q.pop_front());
    end
  end
  initial begin
    // tests need about 85k cycles; the 95k-cycle limit leaves about 10k of margin
    repeat (95000) @(posedge sys_clk_in);
    fail_count++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    sfr_addr_in  = a;
    sfr_wdata_in = d;
    sfr_wr_in    = 1'b1;
    @(negedge sys_clk_in);
    sfr_wr_in    = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk_in);
    sfr_addr_in = a;
    sfr_rd_in   = 1'b1;
    exp_q.push_back(exp);
    @(negedge sys_clk_in);
    sfr_rd_in   = 1'b0;
    @(negedge sys_clk_in);
  endtask : rd
  // ticks every cycle until the overflow reset shows or max is reached
  task automatic ticks(input int max, output int cnt);
    cnt = 0;
    machine_cycle_in = 1'b1;
    while (cnt < max && device_reset_out !== 1'b1) begin
      @(negedge sys_clk_in);
      cnt++;
      rst_pin_in = 1'($random(seed));
    end
    machine_cycle_in = 1'b0;
  endtask : ticks
  // measures the overflow pulse and the pin drive during it
  task automatic pulse(input logic oe_exp);
    int len;
    int bad;
    len = 0;
    bad = 0;
    while (device_reset_out === 1'b1 && len < 500) begin
      if (rst_pin_oe_out !== oe_exp || rst_pin_out !== 1'b1) bad++;
      @(negedge sys_clk_in);
      len++;
    end
    check(16'(len), 16'(owd_pkg::RST_PULSE_CYC));
    check(16'(bad), 16'h0000);
    check(wdt_enabled_out, 1'b0);
  endtask : pulse
  task automatic finish_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    reset_in = 1'b0;
    check(wdt_enabled_out, 1'b0);
    rd(owd_pkg::ADDR_AUX, 8'h00);
    // broken keys: lone second byte, foreign byte between the pair
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_SECOND);
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_FIRST);
    wr(owd_pkg::ADDR_RESTART, 8'h20 + 8'($random(seed) & 8'h3F));
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_SECOND);
    ticks(50, n);
    check(wdt_enabled_out, 1'b0);
    rd(owd_pkg::ADDR_RESTART, 8'h00);
    rd(8'h55, 8'h00);
    $display("test key filter done");
    // other addresses between the key bytes do not break it
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_FIRST);
    wr(8'h90, 8'($random(seed)));
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_SECOND);
    @(negedge sys_clk_in);
    check(wdt_enabled_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(owd_pkg::ADDR_RESTART, 8'($random(seed)) | 8'h01);
    end
    check(wdt_enabled_out, 1'b1);
    // idle bit clear: counting goes on while idle
    idle_in = 1'b1;
    ticks(20000, n);
    idle_in = 1'b0;
    check(n >= 16384 && n <= 16385, 1'b1);
    pulse(1'b1);
    $display("test overflow done");
    // service, then idle halt and reset-out disable
    wr(owd_pkg::ADDR_AUX, 8'h18);
    rd(owd_pkg::ADDR_AUX, 8'h18);
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_FIRST);
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_SECOND);
    ticks(16000, n);
    check(16'(n), 16'h3E80);
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_FIRST);
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_SECOND);
    ticks(16000, n);
    check(16'(n), 16'h3E80);
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_FIRST);
    wr(owd_pkg::ADDR_RESTART, owd_pkg::KEY_SECOND);
    idle_in = 1'b1;
    ticks(20000, n);
    check(16'(n), 16'h4E20);
    idle_in = 1'b0;
    ticks(17000, n);
    check(n >= 16384 && n <= 16385, 1'b1);
    pulse(1'b0);
    rd(owd_pkg::ADDR_AUX, 8'h00);
    $display("test service and idle done");
    finish_test();
  end
endmodule : one_time_enabled_watchdog_tb
